// ---- hdl/cycle_timing_pkg.sv ----
// shared types and timing constants for the instruction cycle timing block
package cycle_timing_pkg;

  localparam int unsigned CLK_PERIOD_NS = 40;
  localparam logic [2:0] CLKS_PER_BUS_CYCLE = 3'h4;
  localparam logic [7:0] MUL_BASE_CLKS = 8'h26;
  localparam logic [7:0] SDIV_MAX_CLKS = 8'h9e;
  localparam logic [7:0] UDIV_MAX_CLKS = 8'h8c;
  localparam logic [7:0] STATIC_BIT_EXTRA_CLKS = 8'h04;

  typedef enum logic [3:0] {
    MODE_DATA_REG, MODE_ADDR_REG, MODE_IND, MODE_POSTINC, MODE_PREDEC,
    MODE_DISP, MODE_INDEX, MODE_ABS_W, MODE_ABS_L, MODE_PC_DISP,
    MODE_PC_INDEX, MODE_IMM
  } ea_mode_t;

  typedef enum logic [1:0] {SIZE_BYTE, SIZE_WORD, SIZE_LONG} op_size_t;

  typedef enum logic [4:0] {
    OP_MOVE, OP_ADD, OP_SUB, OP_AND, OP_OR, OP_CMP, OP_EXCLUSIVE_OR,
    OP_SIGNED_DIVIDE, OP_UNSIGNED_DIVIDE, OP_SIGNED_MULTIPLY, OP_UNSIGNED_MULTIPLY,
    OP_ADD_IMMEDIATE, OP_SUBTRACT_IMMEDIATE, OP_AND_IMMEDIATE, OP_OR_IMMEDIATE,
    OP_XOR_IMMEDIATE, OP_COMPARE_IMMEDIATE, OP_ADD_QUICK, OP_SUBTRACT_QUICK,
    OP_LOAD_QUICK_CONSTANT, OP_CLEAR_OPERAND, OP_NEGATE, OP_NEGATE_WITH_EXTEND,
    OP_NOT, OP_SET_ON_CONDITION, OP_TEST_AND_SET_BYTE, OP_SHIFT_ROTATE,
    OP_BIT_CHANGE, OP_BIT_CLEAR, OP_BIT_SET, OP_BIT_TEST
  } op_class_t;

  // one instruction handed to the sequencer
  typedef struct packed {
    op_class_t op;
    op_size_t size;
    ea_mode_t src;
    ea_mode_t dst;
    logic to_memory;
    logic bit_static;
    logic cond_true;
    logic [5:0] shift_count;
    logic [15:0] source;
  } instr_t;

  // total clocks and bus reads and writes
  typedef struct packed {
    logic [7:0] clocks;
    logic [3:0] reads;
    logic [3:0] writes;
  } cost_t;

  typedef enum logic [1:0] {BUS_IDLE, BUS_READ, BUS_WRITE} bus_kind_t;

endpackage

// ---- hdl/ea_cost.sv ----
// effective address calculation cost per mode and size
`timescale 1ns/100ps
`default_nettype none
module ea_cost
  import cycle_timing_pkg::*;
(
  input wire ea_mode_t mode,
  input wire logic is_long,
  output cost_t cost
);
  always_comb begin
    cost = '0;
    // index register width is not an input: same cost either way
    case (mode)
      MODE_IND, MODE_POSTINC: cost = is_long ? '{8'h08, 4'h2, 4'h0} : '{8'h04, 4'h1, 4'h0};
      MODE_PREDEC: cost = is_long ? '{8'h0a, 4'h2, 4'h0} : '{8'h06, 4'h1, 4'h0};
      MODE_DISP, MODE_ABS_W, MODE_PC_DISP:
        cost = is_long ? '{8'h0c, 4'h3, 4'h0} : '{8'h08, 4'h2, 4'h0};
      MODE_INDEX, MODE_PC_INDEX: cost = is_long ? '{8'h0e, 4'h3, 4'h0} : '{8'h0a, 4'h2, 4'h0};
      MODE_ABS_L: cost = is_long ? '{8'h10, 4'h4, 4'h0} : '{8'h0c, 4'h3, 4'h0};
      MODE_IMM: cost = is_long ? '{8'h08, 4'h2, 4'h0} : '{8'h04, 4'h1, 4'h0};
      default: cost = '0;
    endcase
  end
endmodule
`default_nettype wire

// ---- hdl/cycle_timing.sv ----
// instruction cycle sequencer for a 16-bit bus core
// Operation
// - bus cycles are four clocks, wait extends
// - totals count clocks, reads, writes; rest idle
// - byte/word moves include fetch, reads, writes
// - address register source refused at byte size only
// - long moves write destination twice
// - index register width never changes time
// - marked entries add effective address cost
// - two-operand ops include store and prefetch
// - long add/sub/or base eight if register/immediate
// - divide worst 158 signed, 140 unsigned
// - multiply takes 38 plus twice n
// - unsigned multiply n counts source ones
// - signed multiply n counts bit transitions
// - exclusive-or to register: data source only
// - immediate forms include immediate word fetch
// - single-operand and test-and-set clocks
// - register shifts take base plus twice count
// - memory shifts word only, 8 clocks
// - bit ops dynamic and static timing
// - bit register maxima for data register only
`timescale 1ns/100ps
`default_nettype none
module cycle_timing
  import cycle_timing_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic start,
  input wire instr_t instr,
  input wire logic bus_wait,
  output logic ready,
  output logic illegal,
  output logic done,
  output cost_t cost_q,
  output bus_kind_t bus_kind_q,
  output logic [15:0] elapsed_q
);
  typedef enum logic [1:0] {ST_IDLE, ST_BUS, ST_INTERNAL} state_t;

  state_t state_q;
  cost_t base, ea, total, latched_q;
  logic [4:0] mul_n;
  logic [16:0] mul_ext;
  logic [15:0] trans;
  logic is_long, add_ea, bad;
  logic [3:0] reads_left_q, writes_left_q;
  logic [7:0] idle_left_q;
  logic [1:0] phase_q;
  logic done_q, illegal_q;
  ea_mode_t ea_sel;

  assign is_long = (instr.size == SIZE_LONG);
  assign mul_ext = {instr.source, 1'b0};

  // per bit transition detection for the signed multiply count
  genvar gi;
  generate
    for (gi = 0; gi < 16; gi++) begin : g_trans
      assign trans[gi] = mul_ext[gi+1] ^ mul_ext[gi];
    end
  endgenerate

  always_comb begin
    mul_n = '0;
    for (int i = 0; i < 16; i++) begin
      if (instr.op == OP_UNSIGNED_MULTIPLY) begin
        mul_n = mul_n + {4'h0, instr.source[i]};
      end else begin
        mul_n = mul_n + {4'h0, trans[i]};
      end
    end
  end

  // memory destination of two-operand forms takes the ea cost of the destination
  assign ea_sel = (instr.op == OP_MOVE) ? instr.src :
                  (instr.to_memory ? instr.dst : instr.src);

  ea_cost u_ea (
    .mode(ea_sel),
    .is_long(is_long),
    .cost(ea)
  );

  always_comb begin
    base = '{8'h04, 4'h1, 4'h0};
    add_ea = 1'b1;
    bad = 1'b0;
    case (instr.op)
      OP_MOVE: begin
        add_ea = 1'b0;
        bad = (instr.src == MODE_ADDR_REG) && (instr.size == SIZE_BYTE);
        base = ea;
        base.clocks = base.clocks + 8'h04;
        base.reads = base.reads + 4'h1;
        if (!(instr.dst inside {MODE_DATA_REG, MODE_ADDR_REG})) begin
          base.writes = is_long ? 4'h2 : 4'h1;
          base.clocks = base.clocks + (is_long ? 8'h08 : 8'h04);
          case (instr.dst)
            MODE_DISP, MODE_ABS_W: begin
              base.clocks = base.clocks + 8'h04;
              base.reads = base.reads + 4'h1;
            end
            MODE_INDEX: begin
              base.clocks = base.clocks + 8'h06;
              base.reads = base.reads + 4'h1;
            end
            MODE_ABS_L: begin
              base.clocks = base.clocks + 8'h08;
              base.reads = base.reads + 4'h2;
            end
            default: ;
          endcase
        end
      end
      OP_ADD, OP_SUB, OP_AND, OP_OR, OP_CMP: begin
        if (instr.to_memory && instr.op != OP_CMP) begin
          base = is_long ? '{8'h0c, 4'h1, 4'h2} : '{8'h08, 4'h1, 4'h1};
        end else if (instr.dst == MODE_ADDR_REG) begin
          bad = (instr.size == SIZE_BYTE) || (instr.op == OP_AND) || (instr.op == OP_OR);
          base.clocks = (instr.op == OP_CMP || is_long) ? 8'h06 : 8'h08;
          if (is_long && instr.op != OP_CMP &&
              instr.src inside {MODE_DATA_REG, MODE_ADDR_REG, MODE_IMM}) begin
            base.clocks = 8'h08;
          end
        end else if (is_long) begin
          base.clocks = 8'h06;
          if (instr.op != OP_CMP &&
              instr.src inside {MODE_DATA_REG, MODE_ADDR_REG, MODE_IMM}) begin
            base.clocks = 8'h08;
          end
        end
      end
      OP_EXCLUSIVE_OR: begin
        if (instr.to_memory) begin
          base = is_long ? '{8'h0c, 4'h1, 4'h2} : '{8'h08, 4'h1, 4'h1};
        end else begin
          add_ea = 1'b0;
          bad = (instr.src != MODE_DATA_REG);
          base.clocks = is_long ? 8'h08 : 8'h04;
        end
      end
      OP_SIGNED_DIVIDE: base.clocks = SDIV_MAX_CLKS;
      OP_UNSIGNED_DIVIDE: base.clocks = UDIV_MAX_CLKS;
      OP_SIGNED_MULTIPLY, OP_UNSIGNED_MULTIPLY:
        base.clocks = MUL_BASE_CLKS + {2'b00, mul_n, 1'b0};
      OP_ADD_IMMEDIATE, OP_SUBTRACT_IMMEDIATE, OP_OR_IMMEDIATE, OP_XOR_IMMEDIATE,
      OP_AND_IMMEDIATE, OP_COMPARE_IMMEDIATE: begin
        add_ea = instr.to_memory;
        if (!instr.to_memory) begin
          base = is_long ? '{8'h10, 4'h3, 4'h0} : '{8'h08, 4'h2, 4'h0};
          if (is_long && instr.op inside {OP_AND_IMMEDIATE, OP_COMPARE_IMMEDIATE}) begin
            base.clocks = 8'h0e;
          end
        end else if (instr.op == OP_COMPARE_IMMEDIATE) begin
          base = is_long ? '{8'h0c, 4'h3, 4'h0} : '{8'h08, 4'h2, 4'h0};
        end else begin
          base = is_long ? '{8'h14, 4'h3, 4'h2} : '{8'h0c, 4'h2, 4'h1};
        end
      end
      OP_ADD_QUICK, OP_SUBTRACT_QUICK: begin
        add_ea = instr.to_memory;
        if (instr.to_memory) begin
          base = is_long ? '{8'h0c, 4'h1, 4'h2} : '{8'h08, 4'h1, 4'h1};
        end else if (is_long || (instr.dst == MODE_ADDR_REG && instr.op == OP_SUBTRACT_QUICK)) begin
          base.clocks = 8'h08;
        end
      end
      OP_LOAD_QUICK_CONSTANT: add_ea = 1'b0;
      OP_CLEAR_OPERAND, OP_NEGATE, OP_NEGATE_WITH_EXTEND, OP_NOT: begin
        add_ea = instr.to_memory;
        if (instr.to_memory) begin
          base = is_long ? '{8'h0c, 4'h1, 4'h2} : '{8'h08, 4'h1, 4'h1};
        end else begin
          base.clocks = is_long ? 8'h06 : 8'h04;
        end
      end
      OP_SET_ON_CONDITION: begin
        add_ea = instr.to_memory;
        if (instr.to_memory) begin
          base = '{8'h08, 4'h1, 4'h1};
        end else begin
          base.clocks = instr.cond_true ? 8'h06 : 8'h04;
        end
      end
      OP_TEST_AND_SET_BYTE: begin
        add_ea = instr.to_memory;
        bad = (instr.size != SIZE_BYTE);
        if (instr.to_memory) begin
          base = '{8'h0e, 4'h2, 4'h1};
        end
      end
      OP_SHIFT_ROTATE: begin
        add_ea = instr.to_memory;
        if (instr.to_memory) begin
          bad = (instr.size != SIZE_WORD);
          base = '{8'h08, 4'h1, 4'h1};
        end else begin
          base.clocks = (is_long ? 8'h08 : 8'h06) + {1'b0, instr.shift_count, 1'b0};
        end
      end
      OP_BIT_CHANGE, OP_BIT_CLEAR, OP_BIT_SET, OP_BIT_TEST: begin
        add_ea = instr.to_memory;
        if (instr.to_memory) begin
          base = (instr.op == OP_BIT_TEST) ? '{8'h04, 4'h1, 4'h0} : '{8'h08, 4'h1, 4'h1};
        end else begin
          bad = (instr.dst != MODE_DATA_REG);
          case (instr.op)
            OP_BIT_CLEAR: base.clocks = 8'h0a;
            OP_BIT_TEST: base.clocks = 8'h06;
            default: base.clocks = 8'h08;
          endcase
        end
        if (instr.bit_static) begin
          base.clocks = base.clocks + STATIC_BIT_EXTRA_CLKS;
          base.reads = base.reads + 4'h1;
        end
      end
      default: ;
    endcase
  end

  always_comb begin
    total = base;
    if (add_ea) begin
      total.clocks = base.clocks + ea.clocks;
      total.reads = base.reads + ea.reads;
      total.writes = base.writes + ea.writes;
    end
  end

  assign ready = (state_q == ST_IDLE);
  assign illegal = illegal_q;
  assign done = done_q;
  assign cost_q = latched_q;

  // sequencing: reads, then writes, then idle clocks; each bus cycle is four clocks, held at its last clock while bus_wait
  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= ST_IDLE;
      latched_q <= '0;
      reads_left_q <= '0;
      writes_left_q <= '0;
      idle_left_q <= '0;
      phase_q <= '0;
    end else if (clk_en) begin
      case (state_q)
        ST_IDLE: begin
          if (start && !bad) begin
            latched_q <= total;
            reads_left_q <= total.reads;
            writes_left_q <= total.writes;
            idle_left_q <= total.clocks - {2'b00, total.reads + total.writes, 2'b00};
            phase_q <= '0;
            state_q <= (total.reads + total.writes != 4'h0) ? ST_BUS : ST_INTERNAL;
          end
        end
        ST_BUS: begin
          if (!(phase_q == 2'h3 && bus_wait)) begin
            phase_q <= phase_q + 2'h1;
            if (phase_q == 2'(CLKS_PER_BUS_CYCLE - 3'h1)) begin
              if (reads_left_q != 4'h0) begin
                reads_left_q <= reads_left_q - 4'h1;
              end else begin
                writes_left_q <= writes_left_q - 4'h1;
              end
              if (reads_left_q + writes_left_q == 4'h1) begin
                state_q <= (idle_left_q != 8'h00) ? ST_INTERNAL : ST_IDLE;
              end
            end
          end
        end
        ST_INTERNAL: begin
          idle_left_q <= idle_left_q - 8'h01;
          if (idle_left_q <= 8'h01) begin
            state_q <= ST_IDLE;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      bus_kind_q <= BUS_IDLE;
    end else if (clk_en) begin
      if (state_q == ST_IDLE && start && !bad && total.reads != 4'h0) begin
        bus_kind_q <= BUS_READ;
      end else if (state_q == ST_IDLE && start && !bad && total.writes != 4'h0) begin
        bus_kind_q <= BUS_WRITE;
      end else if (state_q == ST_BUS && phase_q == 2'h3 && !bus_wait) begin
        if (reads_left_q > 4'h1) begin
          bus_kind_q <= BUS_READ;
        end else if (reads_left_q == 4'h1 && writes_left_q != 4'h0) begin
          bus_kind_q <= BUS_WRITE;
        end else if (reads_left_q == 4'h0 && writes_left_q > 4'h1) begin
          bus_kind_q <= BUS_WRITE;
        end else begin
          bus_kind_q <= BUS_IDLE;
        end
      end else if (state_q == ST_IDLE) begin
        bus_kind_q <= BUS_IDLE;
      end
    end
  end

  // elapsed clocks including wait states
  always_ff @(posedge clk) begin
    if (rst) begin
      elapsed_q <= '0;
    end else if (clk_en) begin
      if (state_q == ST_IDLE && start && !bad) begin
        elapsed_q <= 16'h0000;
      end else if (state_q != ST_IDLE) begin
        elapsed_q <= elapsed_q + 16'h0001;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      done_q <= 1'b0;
      illegal_q <= 1'b0;
    end else if (clk_en) begin
      illegal_q <= (state_q == ST_IDLE) && start && bad;
      done_q <= ((state_q == ST_INTERNAL) && idle_left_q <= 8'h01) ||
                ((state_q == ST_BUS) && phase_q == 2'h3 && !bus_wait &&
                 reads_left_q + writes_left_q == 4'h1 && idle_left_q == 8'h00);
    end
  end
endmodule
`default_nettype wire

// ---- dv/bus_memory_model.sv ----
// memory side of the processor bus, optionally stretching each bus cycle
`timescale 1ns/100ps
`default_nettype none
module bus_memory_model
  import cycle_timing_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire bus_kind_t bus_kind_q,
  input wire logic [3:0] wait_clks,
  output var logic bus_wait
);
  logic [1:0] phase_q = 2'h0;
  logic [3:0] left_q = 4'h0;
  logic wait_q = 1'b0;
  assign bus_wait = wait_q;
  // follows the four-clock bus cycle and holds off its last clock
  always_ff @(posedge clk) begin
    if (rst || bus_kind_q == BUS_IDLE) begin
      phase_q <= 2'h0;
      left_q <= 4'h0;
      wait_q <= 1'b0;
    end else if (clk_en && wait_q) begin
      wait_q <= (left_q != 4'h1);
      left_q <= left_q - 4'h1;
    end else if (clk_en) begin
      phase_q <= phase_q + 2'h1;
      if (phase_q == 2'h2 && wait_clks != 4'h0) begin
        wait_q <= 1'b1;
        left_q <= wait_clks;
      end
    end
  end
endmodule
`default_nettype wire

// ---- dv/cycle_timing_properties.sv ----
// concurrent timing checks on the cycle sequencer ports
`timescale 1ns/100ps
`default_nettype none
module cycle_timing_properties
  import cycle_timing_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic start,
  input wire instr_t instr,
  input wire logic bus_wait,
  input wire logic ready,
  input wire logic illegal,
  input wire logic done,
  input wire cost_t cost_q,
  input wire bus_kind_t bus_kind_q,
  input wire logic [15:0] elapsed_q
);
  wire logic take;
  assign take = clk_en && ready && start;
  default clocking @(posedge clk);
  endclocking
  default disable iff (rst);
  word_move_a: assert property (take && instr.op == OP_MOVE && instr.size == SIZE_WORD
    && instr.src == MODE_DATA_REG && instr.dst == MODE_DATA_REG |=> cost_q == 16'h0410)
    else $error("word register move cost wrong");
  long_move_a: assert property (take && instr.op == OP_MOVE && instr.size == SIZE_LONG
    && instr.src == MODE_ABS_L && instr.dst == MODE_ABS_L |=> cost_q == 16'h2472)
    else $error("long absolute move cost wrong");
  byte_addr_a: assert property (take && instr.op == OP_MOVE && instr.size == SIZE_BYTE
    && instr.src == MODE_ADDR_REG |=> illegal)
    else $error("byte move from address register not refused");
  xor_src_a: assert property (take && instr.op == OP_EXCLUSIVE_OR && !instr.to_memory
    && instr.src != MODE_DATA_REG |=> illegal)
    else $error("exclusive-or from non data source not refused");
  umul_time_a: assert property (take && instr.op == OP_UNSIGNED_MULTIPLY
    && instr.src == MODE_DATA_REG
    |=> cost_q.clocks == 8'(38 + 2 * $countones($past(instr.source))))
    else $error("unsigned multiply clocks wrong");
  smul_time_a: assert property (take && instr.op == OP_SIGNED_MULTIPLY
    && instr.src == MODE_DATA_REG |=> cost_q.clocks ==
    8'(38 + 2 * $countones($past(instr.source ^ {instr.source[14:0], 1'b0}))))
    else $error("signed multiply clocks wrong");
  shift_time_a: assert property (take && instr.op == OP_SHIFT_ROTATE && !instr.to_memory
    |=> cost_q.clocks == 8'(($past(instr.size) == SIZE_LONG ? 8 : 6)
    + 2 * $past(instr.shift_count)))
    else $error("register shift clocks wrong");
  idle_done_a: assert property (done |-> bus_kind_q == BUS_IDLE && ready)
    else $error("bus busy at instruction end");
  write_order_a: assert property (bus_kind_q == BUS_WRITE && !done
    |=> bus_kind_q != BUS_READ)
    else $error("read after write in one instruction");
  wait_hold_a: assert property (bus_wait && clk_en && bus_kind_q != BUS_IDLE
    |=> $stable(bus_kind_q) && !done)
    else $error("bus cycle ended during wait");
  mul_c: cover property (take && instr.op == OP_SIGNED_MULTIPLY);
  refuse_c: cover property (illegal);
  stretch_c: cover property (bus_wait && bus_kind_q == BUS_WRITE);
endmodule
bind cycle_timing cycle_timing_properties u_props (.clk(clk), .rst(rst), .clk_en(clk_en),
  .start(start), .instr(instr), .bus_wait(bus_wait), .ready(ready), .illegal(illegal),
  .done(done), .cost_q(cost_q), .bus_kind_q(bus_kind_q), .elapsed_q(elapsed_q));
`default_nettype wire

// ---- dv/tb.sv ----
// self-checking bench for the instruction cycle timing sequencer
`timescale 1ns/100ps
`default_nettype none
module tb;
  import cycle_timing_pkg::*;
  localparam ea_mode_t DRG = MODE_DATA_REG;
  localparam ea_mode_t ARG = MODE_ADDR_REG;
  localparam ea_mode_t IND = MODE_IND;
  localparam ea_mode_t ABL = MODE_ABS_L;
  localparam ea_mode_t IMM = MODE_IMM;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic clk_en = 1'b1;
  logic start = 1'b0;
  instr_t instr = '0;
  logic [3:0] wait_clks = 4'h0;
  logic bus_wait;
  logic ready;
  logic illegal;
  logic done;
  cost_t cost_q;
  bus_kind_t bus_kind_q;
  logic [15:0] elapsed_q;
  int fail_count = 0;
  int tests_run = 0;
  cycle_timing dut (.clk(clk), .rst(rst), .clk_en(clk_en), .start(start), .instr(instr),
    .bus_wait(bus_wait), .ready(ready), .illegal(illegal), .done(done), .cost_q(cost_q),
    .bus_kind_q(bus_kind_q), .elapsed_q(elapsed_q));
  bus_memory_model mem (.clk(clk), .rst(rst), .clk_en(clk_en), .bus_kind_q(bus_kind_q),
    .wait_clks(wait_clks), .bus_wait(bus_wait));
  initial forever #(CLK_PERIOD_NS / 2) clk = ~clk;
  task automatic end_sim;
    $display("checks %0d, mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic chk(logic [31:0] got, logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("FAIL at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // c of zero means the request must be refused; f is {to_memory, bit_static, cond_true}
  task automatic run(op_class_t o, op_size_t s, ea_mode_t a, ea_mode_t b, logic [2:0] f,
      logic [15:0] v, int c, int r, int w);
    int n;
    int rd;
    int wr;
    int bad;
    int e;
    logic seen_wr;
    logic ill;
    n = 0;
    rd = 0;
    wr = 0;
    bad = 0;
    seen_wr = 1'b0;
    e = c + wait_clks * (r + w);
    @(posedge clk);
    start <= 1'b1;
    instr <= '{op: o, size: s, src: a, dst: b, to_memory: f[2], bit_static: f[1],
      cond_true: f[0], shift_count: v[5:0], source: v};
    @(posedge clk);
    start <= 1'b0;
    #1;
    if (c == 0) begin
      ill = illegal;
      @(posedge clk);
      #1;
      chk({31'h0, ill | illegal}, 32'h1);
      chk({31'h0, done | ready}, 32'h1);
      return;
    end
    while (done !== 1'b1 && n < 400) begin
      rd += int'(bus_kind_q === BUS_READ);
      if (bus_kind_q === BUS_WRITE) begin
        seen_wr = 1'b1;
        wr++;
      end
      if (seen_wr && bus_kind_q === BUS_READ) begin
        bad++;
      end
      @(posedge clk);
      #1;
      n++;
    end
    chk(n, e);
    chk({16'h0, elapsed_q}, e);
    chk({16'h0, cost_q}, {16'h0, 8'(c), 4'(r), 4'(w)});
    chk(rd, (4 + wait_clks) * r);
    chk(wr, (4 + wait_clks) * w);
    chk(bad, 0);
    if (n >= 400) begin
      end_sim();
    end
  endtask
  // a held-low clock enable must freeze the sequencer at the first clock of a bus cycle
  task automatic freeze;
    int n;
    n = 0;
    @(posedge clk);
    start <= 1'b1;
    instr <= '0;
    @(posedge clk);
    start <= 1'b0;
    clk_en <= 1'b0;
    repeat (3) @(posedge clk);
    clk_en <= 1'b1;
    #1;
    chk({15'h0, ready, elapsed_q}, 32'h0000_0000);
    chk({30'h0, bus_kind_q}, {30'h0, BUS_READ});
    while (done !== 1'b1 && n < 20) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk({16'h0, elapsed_q}, 32'h0000_0004);
    chk(n, 4);
    if (n >= 20) begin
      end_sim();
    end
  endtask
  task automatic moves;
    run(OP_MOVE, SIZE_WORD, DRG, DRG, 0, 0, 4, 1, 0);
    run(OP_MOVE, SIZE_BYTE, ABL, ABL, 0, 0, 28, 6, 1);
    run(OP_MOVE, SIZE_WORD, ARG, DRG, 0, 0, 4, 1, 0);
    run(OP_MOVE, SIZE_BYTE, ARG, DRG, 0, 0, 0, 0, 0);
    run(OP_MOVE, SIZE_LONG, DRG, IND, 0, 0, 12, 1, 2);
    run(OP_MOVE, SIZE_LONG, ABL, ABL, 0, 0, 36, 7, 2);
    run(OP_MOVE, SIZE_WORD, MODE_INDEX, DRG, 0, 0, 14, 3, 0);
    run(OP_MOVE, SIZE_LONG, MODE_INDEX, DRG, 0, 0, 18, 4, 0);
  endtask
  task automatic alu;
    run(OP_ADD, SIZE_LONG, DRG, DRG, 0, 0, 8, 1, 0);
    run(OP_OR, SIZE_LONG, IMM, DRG, 0, 0, 16, 3, 0);
    run(OP_SUB, SIZE_LONG, IND, DRG, 0, 0, 14, 3, 0);
    run(OP_ADD, SIZE_WORD, DRG, IND, 4, 0, 12, 2, 1);
    run(OP_AND, SIZE_LONG, DRG, IND, 4, 0, 20, 3, 2);
    run(OP_EXCLUSIVE_OR, SIZE_LONG, DRG, DRG, 0, 0, 8, 1, 0);
    run(OP_EXCLUSIVE_OR, SIZE_WORD, IND, DRG, 0, 0, 0, 0, 0);
  endtask
  task automatic muldiv;
    run(OP_UNSIGNED_MULTIPLY, SIZE_WORD, DRG, DRG, 0, 16'hffff, 70, 1, 0);
    run(OP_UNSIGNED_MULTIPLY, SIZE_WORD, DRG, DRG, 0, 16'h0001, 40, 1, 0);
    run(OP_SIGNED_MULTIPLY, SIZE_WORD, DRG, DRG, 0, 16'h5555, 70, 1, 0);
    run(OP_SIGNED_MULTIPLY, SIZE_WORD, DRG, DRG, 0, 16'h0001, 42, 1, 0);
    run(OP_SIGNED_DIVIDE, SIZE_WORD, DRG, DRG, 0, 0, 158, 1, 0);
    run(OP_UNSIGNED_DIVIDE, SIZE_WORD, DRG, DRG, 0, 0, 140, 1, 0);
  endtask
  task automatic immediates;
    op_class_t imm_ops[4] = '{OP_ADD_IMMEDIATE, OP_SUBTRACT_IMMEDIATE, OP_OR_IMMEDIATE,
      OP_XOR_IMMEDIATE};
    op_class_t one_ops[4] = '{OP_CLEAR_OPERAND, OP_NEGATE, OP_NEGATE_WITH_EXTEND, OP_NOT};
    for (int k = 0; k < 4; k++) begin
      run(imm_ops[k], SIZE_WORD, IMM, DRG, 0, 0, 8, 2, 0);
      run(imm_ops[k], SIZE_LONG, IMM, DRG, 0, 0, 16, 3, 0);
      run(one_ops[k], SIZE_WORD, DRG, DRG, 0, 0, 4, 1, 0);
      run(one_ops[k], SIZE_LONG, DRG, DRG, 0, 0, 6, 1, 0);
    end
    run(OP_LOAD_QUICK_CONSTANT, SIZE_LONG, IMM, DRG, 0, 0, 4, 1, 0);
    run(OP_TEST_AND_SET_BYTE, SIZE_BYTE, IND, IND, 4, 0, 18, 3, 1);
    run(OP_SET_ON_CONDITION, SIZE_BYTE, DRG, DRG, 0, 0, 4, 1, 0);
    run(OP_SET_ON_CONDITION, SIZE_BYTE, DRG, DRG, 1, 0, 6, 1, 0);
    run(OP_SET_ON_CONDITION, SIZE_BYTE, IND, IND, 4, 0, 12, 2, 1);
  endtask
  task automatic shifts_bits;
    op_class_t bit_ops[4] = '{OP_BIT_CHANGE, OP_BIT_SET, OP_BIT_CLEAR, OP_BIT_TEST};
    int bit_clks[4] = '{8, 8, 10, 6};
    run(OP_SHIFT_ROTATE, SIZE_WORD, DRG, DRG, 0, 3, 12, 1, 0);
    run(OP_SHIFT_ROTATE, SIZE_LONG, DRG, DRG, 0, 5, 18, 1, 0);
    run(OP_SHIFT_ROTATE, SIZE_WORD, IND, IND, 4, 0, 12, 2, 1);
    run(OP_SHIFT_ROTATE, SIZE_LONG, IND, IND, 4, 0, 0, 0, 0);
    for (int k = 0; k < 4; k++) begin
      run(bit_ops[k], SIZE_LONG, DRG, DRG, 0, 0, bit_clks[k], 1, 0);
      run(bit_ops[k], SIZE_LONG, IMM, DRG, 2, 0, bit_clks[k] + 4, 2, 0);
    end
    run(OP_BIT_SET, SIZE_LONG, DRG, ARG, 0, 0, 0, 0, 0);
  endtask
  task automatic waits;
    wait_clks = 4'h2;
    run(OP_MOVE, SIZE_WORD, DRG, DRG, 0, 0, 4, 1, 0);
    wait_clks = 4'h1;
    run(OP_MOVE, SIZE_LONG, DRG, IND, 0, 0, 12, 1, 2);
    wait_clks = 4'h0;
  endtask
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    moves();
    alu();
    muldiv();
    immediates();
    shifts_bits();
    waits();
    freeze();
    end_sim();
  end
endmodule
`default_nettype wire
